// file: syl_pkg.sv
package syl_pkg;

	// ----------------------------------------------------------------
	// serial word and latch select
	// ----------------------------------------------------------------
	localparam int WORD_W = 24;
	localparam logic [1:0] SEL_CONTROL = 2'h0;
	localparam logic [1:0] SEL_REFERENCE = 2'h1;
	localparam logic [1:0] SEL_FEEDBACK = 2'h2;
	localparam logic [1:0] SEL_TEST = 2'h3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int LOCK_ENTER_NS = 15;
	localparam int LOCK_EXIT_NS = 25;
	// longest times round down, never below one cycle
	localparam int LOCK_ENTER_INT = (LOCK_ENTER_NS / CLK_PERIOD_NS < 1) ?
		1 : LOCK_ENTER_NS / CLK_PERIOD_NS;
	localparam int LOCK_EXIT_INT = (LOCK_EXIT_NS / CLK_PERIOD_NS < 1) ?
		1 : LOCK_EXIT_NS / CLK_PERIOD_NS;
	localparam logic [7:0] LOCK_ENTER_CYC = 8'(LOCK_ENTER_INT);
	localparam logic [7:0] LOCK_EXIT_CYC = 8'(LOCK_EXIT_INT);
	localparam logic [7:0] ERR_SAT = 8'h ff;
	localparam logic [2:0] LOCK_CNT_SHORT = 3'h3;
	localparam logic [2:0] LOCK_CNT_LONG = 3'h5;
	localparam logic [1:0] SYNC_PD_EDGES = 2'h2;

	// ----------------------------------------------------------------
	// monitor output select codes
	// ----------------------------------------------------------------
	localparam logic [2:0] MON_LOW = 3'h0;
	localparam logic [2:0] MON_LOCK = 3'h1;
	localparam logic [2:0] MON_REF_DIV = 3'h2;
	localparam logic [2:0] MON_FB_DIV = 3'h3;
	localparam logic [2:0] MON_HIGH = 3'h7;

	// ----------------------------------------------------------------
	// latch layouts, most significant field first
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] rsv;
		logic powerdown_sync_select;
		logic powerdown_request_bit;
		logic [2:0] pump_current_b;
		logic [2:0] pump_current_a;
		logic [1:0] out_level_sel;
		logic output_hold_until_lock;
		logic pump_gain_select;
		logic pump_tristate;
		logic detector_sign_bit;
		logic [2:0] monitor_sel;
		logic counter_clear_bit;
		logic [1:0] core_bias_sel;
		logic [1:0] latch_select;
	} syl_ctrl_t;

	typedef struct packed {
		logic [1:0] rsv_hi;
		logic pump_gain_select;
		logic [12:0] feedback_ratio;
		logic [5:0] rsv_lo;
		logic [1:0] latch_select;
	} syl_fb_t;

	typedef struct packed {
		logic [1:0] rsv;
		logic [1:0] band_clk_div;
		logic factory_test_bit;
		logic lock_count_select;
		logic [1:0] pulse_width_sel;
		logic [13:0] reference_ratio;
		logic [1:0] latch_select;
	} syl_ref_t;

	// ----------------------------------------------------------------
	// reset values: core bias 5 mA code, smallest legal ratios
	// ----------------------------------------------------------------
	localparam logic [23:0] CTRL_RST = 24'h00_0004;
	localparam logic [23:0] FB_RST = 24'h00_0302;
	localparam logic [23:0] REF_RST = 24'h00_0005;

endpackage

// file: syl_serial_in.sv
`timescale 1ns/1ps
module syl_serial_in
	import syl_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic latch_load_strobe,
	output logic [WORD_W-1:0] word,
	output logic load
);
	logic [WORD_W-1:0] shift_r, shift_nxt;
	logic sck_q_r, le_q_r, load_r, load_nxt;

	// ----------------------------------------------------------------
	// shift on rising serial clock, capture on rising strobe
	// ----------------------------------------------------------------
	always_comb begin
		shift_nxt = shift_r;
		load_nxt = 1'b0;
		if (ser_clk && !sck_q_r) begin
			shift_nxt = {shift_r[WORD_W-2:0], ser_data};
		end
		if (latch_load_strobe && !le_q_r) begin
			load_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shift_r <= '0;
			sck_q_r <= 1'b0;
			le_q_r <= 1'b0;
			load_r <= 1'b0;
		end else begin
			shift_r <= shift_nxt;
			sck_q_r <= ser_clk;
			le_q_r <= latch_load_strobe;
			load_r <= load_nxt;
		end
	end

	// word stays valid with load since shifting and strobe never overlap
	assign word = shift_r;
	assign load = load_r;
endmodule

// file: syl_divider.sv
`timescale 1ns/1ps
module syl_divider (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hold,
	input wire logic step,
	input wire logic [13:0] ratio,
	output logic tick
);
	logic [13:0] cnt_r, cnt_nxt;
	logic tick_r, tick_nxt;

	// ----------------------------------------------------------------
	// counts input edges, one tick per ratio edges; hold = reset state
	// ----------------------------------------------------------------
	always_comb begin
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (hold) begin
			cnt_nxt = '0;
		end else if (step) begin
			if (cnt_r + 14'h0001 >= ratio) begin
				cnt_nxt = '0;
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 14'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule

// file: syl_top.sv
`timescale 1ns/1ps
// Overview of operation
// - 24-bit word in msb first on serial clock rise, copied on strobe rise
// - two low bits pick control, reference, feedback or test latch
// - select 00 loads the control latch
// - select 01 loads the reference divider latch
// - mode bit 0 with request bit 1 powers down at once
// - mode bit 1: power down on second reference divider edge after strobe
// - chip select low disables the device whatever the power-down bits
// - power-down holds counters, tristates pump, clears lock, mutes outputs
// - serial register keeps shifting and latching during power-down
// - control bits 19:14 hold pump current codes a (low) and b (high)
// - bits 13:12 output level, bits 3:2 core bias, 5 mA advised
// - hold-until-lock bit keeps outputs off until lock is seen
// - pump gain select 1 picks current b, 0 picks current a
// - gain also set by feedback latch bit 21; last write wins
// - control bit 9 tristates the charge pump; host keeps it 0 (the test sets it 1 in one row)
// - detector sign 1 positive polarity, 0 negative polarity
// - bits 7:5 choose the signal driven on the monitor pin
// - counter clear bit holds reference and feedback counters reset
// - feedback ratio 13 bits at 20:8, range 3 to 8191
// - reference ratio 14 bits at 15:2, range 1 to 16383
// - reference bits 17:16 select anti-backlash pulse width
// - lock needs five (bit 1) or three (bit 0) cycles under 15 ns
// - lock stays until a cycle shows more than 25 ns error
// - test latch contents ignored; host keeps test bit 0
// - band clock divider divides reference output for band select
// - band clock divide by 1, 2, 4 or 8
module syl_top
	import syl_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic latch_load_strobe,
	input wire logic chip_enable,
	input wire logic ref_in,
	input wire logic fb_in,
	output logic powered_down,
	output logic ref_buffer_enable,
	output logic [2:0] pump_current,
	output logic pump_tristate,
	output logic detector_positive,
	output logic [1:0] pulse_width_sel,
	output logic output_enable,
	output logic [1:0] out_level_sel,
	output logic [1:0] core_bias_sel,
	output logic lock_detect,
	output logic band_clk_tick,
	output logic monitor_output_pin
);
	typedef enum logic [1:0] {
		LD_IDLE = 2'b00,
		LD_REF_FIRST = 2'b01,
		LD_FB_FIRST = 2'b10
	} syl_ld_state_t;
	// ----------------------------------------------------------------
	// serial input and latch storage
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] word;
	logic load, gain_r, gain_nxt;
	syl_ctrl_t ctrl_r, ctrl_nxt;
	syl_fb_t fb_r, fb_nxt;
	syl_ref_t ref_r, ref_nxt;
	// serial register is never gated by power-down
	syl_serial_in u_serial (
		.clk(clk),
		.sys_rst(sys_rst),
		.ser_clk(ser_clk),
		.ser_data(ser_data),
		.latch_load_strobe(latch_load_strobe),
		.word(word),
		.load(load)
	);
	function automatic logic is_sel(input logic [WORD_W-1:0] w,
		input logic [1:0] code);
		return w[1:0] == code;
	endfunction
	always_comb begin
		ctrl_nxt = ctrl_r;
		fb_nxt = fb_r;
		ref_nxt = ref_r;
		gain_nxt = gain_r;
		if (load) begin
			if (is_sel(word, SEL_CONTROL)) begin
				ctrl_nxt = syl_ctrl_t'(word);
				gain_nxt = word[10];
			end
			if (is_sel(word, SEL_REFERENCE)) begin
				ref_nxt = syl_ref_t'(word);
			end
			if (is_sel(word, SEL_FEEDBACK)) begin
				fb_nxt = syl_fb_t'(word);
				gain_nxt = word[21];
			end
			// test latch writes are dropped: test modes stay off
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_r <= syl_ctrl_t'(CTRL_RST);
			fb_r <= syl_fb_t'(FB_RST);
			ref_r <= syl_ref_t'(REF_RST);
			gain_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			fb_r <= fb_nxt;
			ref_r <= ref_nxt;
			gain_r <= gain_nxt;
		end
	end
	// ----------------------------------------------------------------
	// power-down control and counters
	// ----------------------------------------------------------------
	logic soft_pd_r, soft_pd_nxt, sync_arm_r, sync_arm_nxt, pd_r, pd_nxt;
	logic [1:0] sync_cnt_r, sync_cnt_nxt;
	logic ref_tick, fb_tick, ctrl_load, bufen_r;
	assign ctrl_load = load && is_sel(word, SEL_CONTROL);
	always_comb begin
		soft_pd_nxt = soft_pd_r;
		sync_arm_nxt = sync_arm_r;
		sync_cnt_nxt = sync_cnt_r;
		if (ctrl_load) begin
			sync_cnt_nxt = '0;
			if (!word[20]) begin
				soft_pd_nxt = 1'b0;
				sync_arm_nxt = 1'b0;
			end else if (!word[21]) begin
				soft_pd_nxt = 1'b1;
				sync_arm_nxt = 1'b0;
			end else begin
				sync_arm_nxt = !soft_pd_r;
			end
		end else if (sync_arm_r && ref_tick) begin
			if (sync_cnt_r + 2'h1 == SYNC_PD_EDGES) begin
				soft_pd_nxt = 1'b1;
				sync_arm_nxt = 1'b0;
				sync_cnt_nxt = '0;
			end else begin
				sync_cnt_nxt = sync_cnt_r + 2'h1;
			end
		end
		pd_nxt = soft_pd_nxt || !chip_enable;
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			soft_pd_r <= 1'b0;
			sync_arm_r <= 1'b0;
			sync_cnt_r <= '0;
			pd_r <= 1'b1;
			bufen_r <= 1'b0;
		end else begin
			soft_pd_r <= soft_pd_nxt;
			sync_arm_r <= sync_arm_nxt;
			sync_cnt_r <= sync_cnt_nxt;
			pd_r <= pd_nxt;
			bufen_r <= !pd_nxt;
		end
	end
	logic ref_q_r, fb_q_r, cnt_hold;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ref_q_r <= 1'b0;
			fb_q_r <= 1'b0;
		end else begin
			ref_q_r <= ref_in;
			fb_q_r <= fb_in;
		end
	end
	assign cnt_hold = pd_r || ctrl_r.counter_clear_bit;
	syl_divider u_ref_div (
		.clk(clk),
		.sys_rst(sys_rst),
		.hold(cnt_hold),
		.step(ref_in && !ref_q_r),
		.ratio(ref_r.reference_ratio),
		.tick(ref_tick)
	);
	syl_divider u_fb_div (
		.clk(clk),
		.sys_rst(sys_rst),
		.hold(cnt_hold),
		.step(fb_in && !fb_q_r),
		.ratio({1'b0, fb_r.feedback_ratio}),
		.tick(fb_tick)
	);
	// ----------------------------------------------------------------
	// lock detector: phase error in clock cycles between ticks
	// ----------------------------------------------------------------
	syl_ld_state_t ld_r, ld_nxt;
	logic [7:0] err_r, err_nxt, err_meas;
	logic [2:0] good_r, good_nxt, need;
	logic lock_r, lock_nxt, done;
	always_comb begin
		ld_nxt = ld_r;
		err_nxt = err_r;
		good_nxt = good_r;
		lock_nxt = lock_r;
		done = 1'b0;
		err_meas = err_r;
		need = ref_r.lock_count_select ? LOCK_CNT_LONG : LOCK_CNT_SHORT;
		if (err_r != ERR_SAT) begin
			err_nxt = err_r + 8'h01;
		end
		unique case (ld_r)
			LD_IDLE: begin
				err_nxt = 8'h01;
				if (ref_tick && fb_tick) begin
					done = 1'b1;
					err_meas = '0;
				end else if (ref_tick) begin
					ld_nxt = LD_REF_FIRST;
				end else if (fb_tick) begin
					ld_nxt = LD_FB_FIRST;
				end
			end
			LD_REF_FIRST: begin
				if (fb_tick) begin
					done = 1'b1;
					ld_nxt = LD_IDLE;
				end
			end
			LD_FB_FIRST: begin
				if (ref_tick) begin
					done = 1'b1;
					ld_nxt = LD_IDLE;
				end
			end
			default: begin
				ld_nxt = LD_IDLE;
			end
		endcase
		if (done) begin
			if (err_meas < LOCK_ENTER_CYC) begin
				if (good_r < need) begin
					good_nxt = good_r + 3'h1;
				end
				if (good_r + 3'h1 >= need) begin
					lock_nxt = 1'b1;
				end
			end else begin
				good_nxt = '0;
			end
			if (err_meas > LOCK_EXIT_CYC) begin
				lock_nxt = 1'b0;
			end
		end
		if (pd_r) begin
			ld_nxt = LD_IDLE;
			good_nxt = '0;
			lock_nxt = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ld_r <= LD_IDLE;
			err_r <= '0;
			good_r <= '0;
			lock_r <= 1'b0;
		end else begin
			ld_r <= ld_nxt;
			err_r <= err_nxt;
			good_r <= good_nxt;
			lock_r <= lock_nxt;
		end
	end
	// ----------------------------------------------------------------
	// band select clock divider, registered analog controls, monitor
	// ----------------------------------------------------------------
	logic [2:0] band_cnt_r, band_cnt_nxt, band_mask, cur_r, cur_nxt;
	logic band_tick_r, band_tick_nxt, tri_r, tri_nxt, sign_r, sign_nxt;
	logic oe_r, oe_nxt, mon_r, mon_nxt;
	always_comb begin
		band_mask = 3'((4'h1 << ref_r.band_clk_div) - 4'h1);
		band_cnt_nxt = band_cnt_r;
		band_tick_nxt = 1'b0;
		if (cnt_hold) begin
			band_cnt_nxt = '0;
		end else if (ref_tick) begin
			band_tick_nxt = (band_cnt_r & band_mask) == band_mask;
			band_cnt_nxt = band_cnt_r + 3'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			band_cnt_r <= '0;
			band_tick_r <= 1'b0;
		end else begin
			band_cnt_r <= band_cnt_nxt;
			band_tick_r <= band_tick_nxt;
		end
	end
	// pump and outputs follow the power-down register in the same cycle
	always_comb begin
		cur_nxt = gain_r ? ctrl_r.pump_current_b :
			ctrl_r.pump_current_a;
		tri_nxt = pd_nxt || ctrl_r.pump_tristate;
		sign_nxt = ctrl_r.detector_sign_bit;
		oe_nxt = !pd_nxt && (lock_r || !ctrl_r.output_hold_until_lock);
		unique case (ctrl_r.monitor_sel)
			MON_LOCK: mon_nxt = lock_r;
			MON_REF_DIV: mon_nxt = ref_tick;
			MON_FB_DIV: mon_nxt = fb_tick;
			MON_HIGH: mon_nxt = 1'b1;
			default: mon_nxt = 1'b0;
		endcase
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cur_r <= '0;
			tri_r <= 1'b1;
			sign_r <= 1'b0;
			oe_r <= 1'b0;
			mon_r <= 1'b0;
		end else begin
			cur_r <= cur_nxt;
			tri_r <= tri_nxt;
			sign_r <= sign_nxt;
			oe_r <= oe_nxt;
			mon_r <= mon_nxt;
		end
	end
	assign powered_down = pd_r;
	assign ref_buffer_enable = bufen_r;
	assign pump_current = cur_r;
	assign pump_tristate = tri_r;
	assign detector_positive = sign_r;
	assign pulse_width_sel = ref_r.pulse_width_sel;
	assign output_enable = oe_r;
	assign out_level_sel = ctrl_r.out_level_sel;
	assign core_bias_sel = ctrl_r.core_bias_sel;
	assign lock_detect = lock_r;
	assign band_clk_tick = band_tick_r;
	assign monitor_output_pin = mon_r;
endmodule

// file: syl_assertions.sv
`timescale 1ns/1ps
module syl_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic latch_load_strobe,
	input wire logic chip_enable,
	input wire logic powered_down,
	input wire logic ref_buffer_enable,
	input wire logic pump_tristate,
	input wire logic output_enable,
	input wire logic lock_detect,
	input wire logic band_clk_tick,
	input wire logic [1:0] pulse_width_sel,
	input wire logic [1:0] out_level_sel
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------------------------------
	// power-down
	// ----------------------------------------------------------------
	property p_bufen;
		ref_buffer_enable == !powered_down;
	endproperty
	a_bufen: assert property (p_bufen)
		else $error("reference buffer enable wrong");
	property p_ce_pd;
		!chip_enable |=> powered_down;
	endproperty
	a_ce_pd: assert property (p_ce_pd)
		else $error("chip select low did not power down");
	property p_pd_pump;
		powered_down [*2] |-> pump_tristate && !output_enable;
	endproperty
	a_pd_pump: assert property (p_pd_pump)
		else $error("pump or outputs active in power-down");
	property p_pd_lock;
		powered_down [*3] |-> !lock_detect;
	endproperty
	a_pd_lock: assert property (p_pd_lock)
		else $error("lock kept in power-down");
	property p_pd_band;
		powered_down [*4] |-> !band_clk_tick;
	endproperty
	a_pd_band: assert property (p_pd_band)
		else $error("band clock ticks in power-down");
	property p_oe;
		output_enable |-> !powered_down;
	endproperty
	a_oe: assert property (p_oe)
		else $error("outputs on while powered down");
	// ----------------------------------------------------------------
	// latch loads and band clock
	// ----------------------------------------------------------------
	property p_tick;
		band_clk_tick |=> !band_clk_tick;
	endproperty
	a_tick: assert property (p_tick)
		else $error("band clock tick longer than one cycle");
	property p_pw;
		$changed(pulse_width_sel) |->
			$past(latch_load_strobe, 2) && !$past(latch_load_strobe, 3);
	endproperty
	a_pw: assert property (p_pw)
		else $error("pulse width changed without strobe");
	property p_lvl;
		$changed(out_level_sel) |->
			$past(latch_load_strobe, 2) && !$past(latch_load_strobe, 3);
	endproperty
	a_lvl: assert property (p_lvl)
		else $error("output level changed without strobe");
	c_lock: cover property ($rose(lock_detect));
	c_pd: cover property ($rose(powered_down));
	c_tick: cover property (band_clk_tick);
endmodule
bind syl_top syl_checker syl_checker_inst (.clk, .sys_rst,
	.latch_load_strobe, .chip_enable, .powered_down, .ref_buffer_enable,
	.pump_tristate, .output_enable, .lock_detect, .band_clk_tick,
	.pulse_width_sel, .out_level_sel);

// file: syl_host_model.sv
`timescale 1ns/1ps
module syl_host (
	input wire logic clk,
	output logic ser_clk,
	output logic ser_data,
	output logic latch_load_strobe
);
	initial begin
		ser_clk = 1'h0;
		ser_data = 1'h0;
		latch_load_strobe = 1'h0;
	end
	// serial clock rests low between words, data line toggles
	task automatic send(input logic [23:0] w, input int hold_cyc);
		for (int i = 23; i >= 0; i--) begin
			ser_data = w[i];
			repeat (hold_cyc) @(negedge clk);
			ser_clk = 1'h1;
			repeat (hold_cyc) @(negedge clk);
			ser_clk = 1'h0;
		end
		latch_load_strobe = 1'h1;
		repeat (2) @(negedge clk);
		latch_load_strobe = 1'h0;
		ser_data = ~ser_data;
	endtask
endmodule

// file: syl_top_test.sv
`timescale 1ns/1ps
module syl_top_test;
	typedef struct packed {
		logic [23:0] w;
		logic [2:0] pc;
		logic tri_s;
		logic pos;
		logic [1:0] lvl;
		logic [1:0] bias;
		logic [1:0] pw;
	} syl_row_t;
	logic clk = 1'h0;
	logic sys_rst = 1'h1;
	logic chip_enable = 1'h1;
	logic ref_in = 1'h0;
	logic fb_in = 1'h0;
	logic ser_clk, ser_data, latch_load_strobe;
	logic powered_down, ref_buffer_enable, pump_tristate;
	logic detector_positive, output_enable, lock_detect;
	logic band_clk_tick, monitor_output_pin;
	logic [2:0] pump_current;
	logic [1:0] pulse_width_sel, out_level_sel, core_bias_sel;
	int error_cnt = 0;
	int comparisons = 0;
	int band_seen = 0;
	int band_base = 0;
	// reserved bits written as zero, except in the all-ones test latch row
	syl_row_t rows [6] = '{
		'{24'h0a_b504, 3'h5, 1'h0, 1'h1, 2'h3, 2'h1, 2'h0},
		'{24'h03_9208, 3'h6, 1'h1, 1'h0, 2'h1, 2'h2, 2'h0},
		'{24'h20_0302, 3'h1, 1'h1, 1'h0, 2'h1, 2'h2, 2'h0},
		'{24'h02_0005, 3'h1, 1'h1, 1'h0, 2'h1, 2'h2, 2'h2},
		'{24'hff_ffff, 3'h1, 1'h1, 1'h0, 2'h1, 2'h2, 2'h2},
		'{24'h0e_050c, 3'h7, 1'h0, 1'h1, 2'h0, 2'h3, 2'h2}};

	always #4 clk = ~clk;

	// band ticks are one cycle wide, counted where they have settled
	always @(negedge clk) begin
		if (band_clk_tick) begin
			band_seen++;
		end
	end

	syl_top syl_top_inst (.clk, .sys_rst, .ser_clk, .ser_data,
		.latch_load_strobe, .chip_enable, .ref_in, .fb_in, .powered_down,
		.ref_buffer_enable, .pump_current, .pump_tristate, .detector_positive,
		.pulse_width_sel, .output_enable, .out_level_sel, .core_bias_sel,
		.lock_detect, .band_clk_tick, .monitor_output_pin);
	syl_host syl_host_inst (.clk, .ser_clk, .ser_data, .latch_load_strobe);

	task automatic chk(input string nm, input logic [3:0] e,
		input logic [3:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic print_verdict;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic edge_in(input logic r, input logic f);
		ref_in = r;
		fb_in = f;
		repeat (2) @(negedge clk);
		ref_in = 1'h0;
		fb_in = 1'h0;
		repeat (2) @(negedge clk);
	endtask

	task automatic put(input logic [23:0] w);
		syl_host_inst.send(w, 2);
		repeat (4) @(negedge clk);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end

	initial begin
		repeat (5) @(negedge clk);
		chk("pd", 4'h1, 4'(powered_down));
		chk("tri", 4'h1, 4'(pump_tristate));
		chk("oe", 4'h0, 4'(output_enable));
		chk("buf", 4'h0, 4'(ref_buffer_enable));
		chk("bias", 4'h1, 4'(core_bias_sel));
		sys_rst = 1'h0;
		repeat (2) @(negedge clk);
		chk("pd", 4'h0, 4'(powered_down));
		foreach (rows[i]) begin
			put(rows[i].w);
			chk("cur", 4'(rows[i].pc), 4'(pump_current));
			chk("tri", 4'(rows[i].tri_s), 4'(pump_tristate));
			chk("pos", 4'(rows[i].pos), 4'(detector_positive));
			chk("lvl", 4'(rows[i].lvl), 4'(out_level_sel));
			chk("bias", 4'(rows[i].bias), 4'(core_bias_sel));
			chk("pw", 4'(rows[i].pw), 4'(pulse_width_sel));
		end
		syl_host_inst.send(24'h0e_0d0c, 5);
		repeat (4) @(negedge clk);
		chk("oe", 4'h0, 4'(output_enable));
		for (int p = 0; p < 3; p++) begin
			chk("lock", 4'h0, 4'(lock_detect));
			edge_in(1'h0, 1'h1);
			edge_in(1'h0, 1'h1);
			edge_in(1'h1, 1'h1);
			repeat (3) @(negedge clk);
		end
		chk("lock", 4'h1, 4'(lock_detect));
		chk("oe", 4'h1, 4'(output_enable));
		edge_in(1'h1, 1'h0);
		repeat (3) edge_in(1'h0, 1'h1);
		repeat (3) @(negedge clk);
		chk("lock", 4'h0, 4'(lock_detect));
		chk("oe", 4'h0, 4'(output_enable));
		put(24'h3e_050c);
		chk("pd", 4'h0, 4'(powered_down));
		edge_in(1'h1, 1'h0);
		repeat (2) @(negedge clk);
		chk("pd", 4'h0, 4'(powered_down));
		edge_in(1'h1, 1'h0);
		repeat (2) @(negedge clk);
		chk("pd", 4'h1, 4'(powered_down));
		chk("tri", 4'h1, 4'(pump_tristate));
		chk("buf", 4'h0, 4'(ref_buffer_enable));
		put(24'h0e_050c);
		chk("pd", 4'h0, 4'(powered_down));
		put(24'h1a_b504);
		chk("pd", 4'h1, 4'(powered_down));
		chk("cur", 4'h5, 4'(pump_current));
		chk("lvl", 4'h3, 4'(out_level_sel));
		put(24'h0a_b504);
		chk("pd", 4'h0, 4'(powered_down));
		chip_enable = 1'h0;
		repeat (2) @(negedge clk);
		chk("pd", 4'h1, 4'(powered_down));
		chip_enable = 1'h1;
		repeat (3) @(negedge clk);
		chk("pd", 4'h0, 4'(powered_down));
		chk("buf", 4'h1, 4'(ref_buffer_enable));
		// monitor forced high, then reference divide of band clock by 4
		put(24'h0e_05ec);
		chk("mon", 4'h1, 4'(monitor_output_pin));
		put(24'h22_0005);
		band_base = band_seen;
		repeat (8) edge_in(1'h1, 1'h0);
		chk("band", 4'h2, 4'(band_seen - band_base));
		chk("pw", 4'h2, 4'(pulse_width_sel));
		// counter clear holds the counters, so no band ticks appear
		put(24'h0e_05fc);
		band_base = band_seen;
		repeat (4) edge_in(1'h1, 1'h0);
		chk("band", 4'h0, 4'(band_seen - band_base));
		print_verdict();
	end
endmodule
